// ### hdl/lsamp_defs.vh
// Constants shared by the logic bus sampler files
`ifndef LSAMP_DEFS_VH
`define LSAMP_DEFS_VH
// Line and group geometry
`define LSAMP_NLINES 16
`define LSAMP_POD 8
`define LSAMP_NGRP 4
`define LSAMP_LVL_W 8
// Threshold reset value and logic-family presets
`define LSAMP_THR_RESET 8'h80
`define LSAMP_TECH_MANUAL 3'h0
`define LSAMP_TECH_CMOS33 3'h1
`define LSAMP_TECH_CMOS25 3'h2
`define LSAMP_TECH_CMOS18 3'h3
`define LSAMP_TECH_TTL 3'h4
`define LSAMP_TECH_ECL 3'h5
`define LSAMP_THR_CMOS33 8'h55
`define LSAMP_THR_CMOS25 8'h40
`define LSAMP_THR_CMOS18 8'h2e
`define LSAMP_THR_TTL 8'h38
`define LSAMP_THR_ECL 8'h10
// Hysteresis modes and amounts in level codes
`define LSAMP_HYS_NORMAL 2'h0
`define LSAMP_HYS_MAX 2'h1
`define LSAMP_HYS_ROBUST 2'h2
`define LSAMP_HYS_AMT_NORMAL 8'h02
`define LSAMP_HYS_AMT_MAX 8'h10
`define LSAMP_HYS_AMT_RISE 8'h08
`define LSAMP_HYS_AMT_FALL 8'h18
// Bus value formats
`define LSAMP_FMT_HEX 4'h0
`define LSAMP_FMT_OCT 4'h1
`define LSAMP_FMT_BIN 4'h2
`define LSAMP_FMT_ASCII 4'h3
`define LSAMP_FMT_STRING 4'h4
`define LSAMP_FMT_SIGNED 4'h5
`define LSAMP_FMT_UNSIGNED 4'h6
`define LSAMP_FMT_SYMBOLIC 4'h7
`define LSAMP_FMT_AUTO 4'h8
// Delay line depth and fixed probe-path compensation in samples
`define LSAMP_DLY_DEPTH 64
`define LSAMP_DLY_SEL_W 6
`define LSAMP_PATH_COMP 6'h03
`endif

// ### hdl/lsamp_cmp.v
// Threshold comparator with selectable hysteresis for one line
`timescale 1ns/10ps
`include "lsamp_defs.vh"
module lsamp_cmp (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Level sample and threshold setting
   input wire [7:0] level_in,
   input wire [7:0] thr_in,
   input wire [1:0] hys_in,
   // Qualified logic state
   output reg state_out
);

   reg [7:0] amt_rise;
   reg [7:0] amt_fall;
   wire [8:0] up_lim;
   wire [8:0] dn_lim;

   // Robust mode uses a wider band on the falling side
   always @* begin
      amt_rise = `LSAMP_HYS_AMT_NORMAL;
      amt_fall = `LSAMP_HYS_AMT_NORMAL;
      if (hys_in == `LSAMP_HYS_MAX) begin
         amt_rise = `LSAMP_HYS_AMT_MAX;
         amt_fall = `LSAMP_HYS_AMT_MAX;
      end else if (hys_in == `LSAMP_HYS_ROBUST) begin
         amt_rise = `LSAMP_HYS_AMT_RISE; // RULE5
         amt_fall = `LSAMP_HYS_AMT_FALL; // RULE5
      end
   end

   // Nine bits so the band never wraps at the ends of the range
   assign up_lim = {1'b0, thr_in} + {1'b0, amt_rise};
   assign dn_lim = {1'b0, level_in} + {1'b0, amt_fall};

   // Above the band gives 1, below gives 0, inside keeps the old state
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_out <= 1'b0;
      end else if (!state_out && ({1'b0, level_in} > up_lim)) begin
         state_out <= 1'b1; // RULE4
      end else if (state_out && (dn_lim <= {1'b0, thr_in})) begin
         state_out <= 1'b0; // RULE4
      end
   end

endmodule // lsamp_cmp

// ### hdl/lsamp_dly.v
// Programmable whole-sample delay line for one qualified line
`timescale 1ns/10ps
`include "lsamp_defs.vh"
module lsamp_dly (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Sample and delay selection
   input wire bit_in,
   input wire [5:0] sel_in,
   // Delayed sample
   output reg bit_out
);

   reg [`LSAMP_DLY_DEPTH-1:0] taps;

   // Shift history; every line adds the same two cycles of pipeline
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         taps <= {`LSAMP_DLY_DEPTH{1'b0}};
         bit_out <= 1'b0;
      end else begin
         taps <= {taps[`LSAMP_DLY_DEPTH-2:0], bit_in};
         bit_out <= taps[sel_in]; // RULE21
      end
   end

endmodule // lsamp_dly

// ### hdl/lsamp_top.v
// Logic bus sampler: thresholds, skew, group control and bus assembly
// Functional notes
// RULE1 - Sixteen input lines arrive as two pods of eight lines.
// RULE2 - Up to four groups, each enableable, each with selectable member lines.
// RULE3 - Enabling a group disables enabled groups sharing a line and flags it.
// RULE4 - Each sample stores 1 above threshold, else 0.
// RULE5 - Hysteresis normal, maximum or robust; robust has distinct rise and fall.
// RULE6 - After reset coupling is on: one threshold for all lines and groups.
// RULE7 - Enabled groups share the threshold of the most recently enabled group.
// RULE8 - Preset loads threshold everywhere; a direct threshold write selects manual.
// RULE9 - Unclocked bus state every sample; clocked only at qualifying edges.
// RULE10 - Clocked group uses one selectable line as clock when clocked mode set.
// RULE11 - Per-group slope picks rising or falling clock edge.
// RULE12 - Only clocked groups give results: word plus timestamp per edge.
// RULE13 - Integer words at most sixteen bits; signed form keeps sign.
// RULE14 - Binary output is signed for signed format, unsigned otherwise.
// RULE15 - Each line has its own programmable delay.
// RULE16 - One global delay adds to every line's delay.
// RULE17 - Fixed probe-path delay is compensated automatically.
// RULE18 - Per-line member enables; pod control sets or clears eight at once.
// RULE19 - Per-group format: hex, octal, binary, ASCII, string, signed, etc.
// RULE20 - Bus word packs enabled lines ascending, lowest line in bit 0.
// RULE21 - Delays are whole samples, before edge detection and assembly.
`timescale 1ns/10ps
`include "lsamp_defs.vh"
module lsamp_top (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Converted levels of the sixteen lines, eight bits each, line 0 lowest
   input wire [127:0] level_in,
   // Threshold and hysteresis control
   input wire thr_wr_in,
   input wire [7:0] thr_val_in,
   input wire [1:0] hys_val_in,
   input wire tech_wr_in,
   input wire [2:0] tech_val_in,
   input wire couple_wr_in,
   input wire couple_val_in,
   // Group control, addressed by grp_idx_in
   input wire [1:0] grp_idx_in,
   input wire en_wr_in,
   input wire en_val_in,
   input wire mask_wr_in,
   input wire [15:0] mask_val_in,
   input wire pod_wr_in,
   input wire pod_sel_in,
   input wire pod_val_in,
   input wire cfg_wr_in,
   input wire clk_mode_in,
   input wire [3:0] clk_src_in,
   input wire slope_in,
   input wire [3:0] fmt_in,
   // Skew control
   input wire skew_wr_in,
   input wire [3:0] skew_line_in,
   input wire [3:0] skew_val_in,
   input wire gskew_wr_in,
   input wire [3:0] gskew_val_in,
   // Status
   output reg [15:0] line_out,
   output reg [3:0] grp_en_out,
   output reg conflict_out,
   output reg [2:0] tech_sel_out,
   output reg couple_out,
   output reg [7:0] act_thr_out,
   output reg [1:0] act_hys_out,
   // Bus state and clocked results
   output reg [63:0] bus_state_out,
   output reg [3:0] res_valid_out,
   output reg [63:0] res_word_out,
   output reg [63:0] res_sext_out,
   output reg [127:0] res_time_out,
   output reg [3:0] res_signed_out
);

   ////////////////////////////////////////////////////////////////////////
   // Configuration storage
   reg [15:0] grp_mask [0:3];
   reg [7:0] grp_thr [0:3];
   reg [1:0] grp_hys [0:3];
   reg [3:0] grp_clocked;
   reg [3:0] grp_src [0:3];
   reg [3:0] grp_slope;
   reg [3:0] grp_fmt [0:3];
   reg [3:0] line_skew [0:15];
   reg [3:0] gskew;
   reg [31:0] tstamp;
   reg [15:0] prev_line;
   reg [7:0] preset_thr;
   reg [3:0] overlap;
   reg [15:0] pod_mask;
   reg [127:0] line_thr;
   reg [31:0] line_hys;
   reg [63:0] asm_word;
   reg [63:0] asm_sext;
   reg [3:0] edge_hit;
   reg [4:0] width;
   reg [3:0] k;
   wire [15:0] qual;
   wire [15:0] dly;
   integer g;
   integer i;
   integer j;

   ////////////////////////////////////////////////////////////////////////
   // Preset decode and conflict detection for the addressed group
   always @* begin
      preset_thr = `LSAMP_THR_RESET;
      case (tech_val_in)
         `LSAMP_TECH_CMOS33: preset_thr = `LSAMP_THR_CMOS33;
         `LSAMP_TECH_CMOS25: preset_thr = `LSAMP_THR_CMOS25;
         `LSAMP_TECH_CMOS18: preset_thr = `LSAMP_THR_CMOS18;
         `LSAMP_TECH_TTL: preset_thr = `LSAMP_THR_TTL;
         `LSAMP_TECH_ECL: preset_thr = `LSAMP_THR_ECL;
         default: preset_thr = act_thr_out;
      endcase
      pod_mask = pod_sel_in ? 16'hff00 : 16'h00ff; // RULE18
      for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
         overlap[g] = grp_en_out[g] && (g != grp_idx_in) &&
                      (|(grp_mask[g] & grp_mask[grp_idx_in])); // RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Group, threshold and skew control
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         grp_en_out <= 4'h0;
         conflict_out <= 1'b0;
         tech_sel_out <= `LSAMP_TECH_MANUAL;
         couple_out <= 1'b1; // RULE6
         act_thr_out <= `LSAMP_THR_RESET;
         act_hys_out <= `LSAMP_HYS_NORMAL;
         grp_clocked <= 4'h0;
         grp_slope <= 4'h0;
         gskew <= 4'h0;
         for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
            grp_mask[g] <= 16'h0000;
            grp_thr[g] <= `LSAMP_THR_RESET;
            grp_hys[g] <= `LSAMP_HYS_NORMAL;
            grp_src[g] <= 4'h0;
            grp_fmt[g] <= `LSAMP_FMT_HEX;
         end
         for (i = 0; i < `LSAMP_NLINES; i = i + 1) begin
            line_skew[i] <= 4'h0;
         end
      end else begin
         conflict_out <= 1'b0;
         if (couple_wr_in) begin
            couple_out <= couple_val_in;
         end
         // Member enables: whole mask or one pod at a time
         if (mask_wr_in) begin
            grp_mask[grp_idx_in] <= mask_val_in; // RULE2
         end else if (pod_wr_in) begin
            grp_mask[grp_idx_in] <= pod_val_in ? (grp_mask[grp_idx_in] | pod_mask)
                                               : (grp_mask[grp_idx_in] & ~pod_mask); // RULE18
         end
         if (cfg_wr_in) begin
            grp_clocked[grp_idx_in] <= clk_mode_in; // RULE10
            grp_src[grp_idx_in] <= clk_src_in; // RULE10
            grp_slope[grp_idx_in] <= slope_in; // RULE11
            grp_fmt[grp_idx_in] <= fmt_in; // RULE19
         end
         // A preset reaches every group and every line at once
         if (tech_wr_in) begin
            tech_sel_out <= tech_val_in;
            if (tech_val_in != `LSAMP_TECH_MANUAL) begin
               act_thr_out <= preset_thr; // RULE8
               for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
                  grp_thr[g] <= preset_thr; // RULE8
               end
            end
         end else if (thr_wr_in) begin
            tech_sel_out <= `LSAMP_TECH_MANUAL; // RULE8
            grp_thr[grp_idx_in] <= thr_val_in;
            grp_hys[grp_idx_in] <= hys_val_in;
            if (couple_out) begin
               act_thr_out <= thr_val_in; // RULE6
               act_hys_out <= hys_val_in; // RULE6
               for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
                  grp_thr[g] <= thr_val_in;
                  grp_hys[g] <= hys_val_in;
               end
            end else if (grp_en_out[grp_idx_in]) begin
               act_thr_out <= thr_val_in; // RULE7
               act_hys_out <= hys_val_in; // RULE7
            end
         end
         // Enabling evicts overlapping groups and takes over the threshold
         if (en_wr_in) begin
            if (en_val_in) begin
               grp_en_out <= (grp_en_out & ~overlap) | (4'h1 << grp_idx_in); // RULE3
               conflict_out <= |overlap; // RULE3
               if (!thr_wr_in && !tech_wr_in) begin
                  act_thr_out <= grp_thr[grp_idx_in]; // RULE7
                  act_hys_out <= grp_hys[grp_idx_in]; // RULE7
               end
            end else begin
               grp_en_out <= grp_en_out & ~(4'h1 << grp_idx_in); // RULE2
            end
         end
         if (skew_wr_in) begin
            line_skew[skew_line_in] <= skew_val_in; // RULE15
         end
         if (gskew_wr_in) begin
            gskew <= gskew_val_in; // RULE16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Threshold per line: shared value unless decoupled and outside any
   // enabled group, where the lowest group holding the line sets it
   always @* begin
      line_thr = {16{act_thr_out}};
      line_hys = {16{act_hys_out}};
      for (i = 0; i < `LSAMP_NLINES; i = i + 1) begin
         if (!couple_out) begin
            for (g = `LSAMP_NGRP - 1; g >= 0; g = g - 1) begin
               if (grp_mask[g][i] && !(|(grp_en_out & {grp_mask[3][i], grp_mask[2][i],
                                                       grp_mask[1][i], grp_mask[0][i]}))) begin
                  line_thr[i*8 +: 8] = grp_thr[g]; // RULE7
                  line_hys[i*2 +: 2] = grp_hys[g];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-line comparator and delay; path compensation keeps digital
   // samples level with the analog path even at zero skew
   genvar n;
   generate
      for (n = 0; n < `LSAMP_NLINES; n = n + 1) begin : line_gen
         wire [5:0] sel;
         assign sel = {2'b00, line_skew[n]} + {2'b00, gskew} + `LSAMP_PATH_COMP; // RULE17
         lsamp_cmp u_cmp (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .level_in(level_in[n*8 +: 8]), // RULE1
            .thr_in(line_thr[n*8 +: 8]),
            .hys_in(line_hys[n*2 +: 2]),
            .state_out(qual[n])
         );
         lsamp_dly u_dly (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .bit_in(qual[n]),
            .sel_in(sel), // RULE15 RULE16
            .bit_out(dly[n])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Bus assembly, sign extension and edge qualification per group
   always @* begin
      asm_word = 64'h0000_0000_0000_0000;
      asm_sext = 64'h0000_0000_0000_0000;
      edge_hit = 4'h0;
      width = 5'h00;
      k = 4'h0;
      for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
         k = 4'h0;
         width = 5'h00;
         for (i = 0; i < `LSAMP_NLINES; i = i + 1) begin
            if (grp_mask[g][i]) begin
               asm_word[g*16 + k] = dly[i]; // RULE20
               k = k + 4'h1;
               width = width + 5'h01;
            end
         end
         // Sign bit is the highest member line, so values fit sixteen bits
         for (j = 0; j < 16; j = j + 1) begin
            if ((j < width) || (width == 5'h00)) begin
               asm_sext[g*16 + j] = asm_word[g*16 + j]; // RULE13
            end else begin
               asm_sext[g*16 + j] = asm_word[g*16 + width - 1]; // RULE13
            end
         end
         edge_hit[g] = grp_en_out[g] && grp_clocked[g] &&
                       (grp_slope[g] ? (prev_line[grp_src[g]] && !dly[grp_src[g]])
                                     : (!prev_line[grp_src[g]] && dly[grp_src[g]])); // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus state and result entries; the timestamp counts delayed samples
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         line_out <= 16'h0000;
         prev_line <= 16'h0000;
         tstamp <= 32'h0000_0000;
         bus_state_out <= 64'h0000_0000_0000_0000;
         res_valid_out <= 4'h0;
         res_word_out <= 64'h0000_0000_0000_0000;
         res_sext_out <= 64'h0000_0000_0000_0000;
         res_time_out <= {4{32'h0000_0000}};
         res_signed_out <= 4'h0;
      end else begin
         line_out <= dly;
         prev_line <= dly;
         tstamp <= tstamp + 32'h0000_0001;
         for (g = 0; g < `LSAMP_NGRP; g = g + 1) begin
            res_signed_out[g] <= (grp_fmt[g] == `LSAMP_FMT_SIGNED); // RULE14
            res_valid_out[g] <= edge_hit[g]; // RULE12
            if (grp_en_out[g] && (!grp_clocked[g] || edge_hit[g])) begin
               bus_state_out[g*16 +: 16] <= asm_word[g*16 +: 16]; // RULE9
            end
            if (edge_hit[g]) begin
               res_word_out[g*16 +: 16] <= asm_word[g*16 +: 16]; // RULE12
               res_sext_out[g*16 +: 16] <= asm_sext[g*16 +: 16]; // RULE13
               res_time_out[g*32 +: 32] <= tstamp; // RULE12
            end
         end
      end
   end

endmodule // lsamp_top

// ### tb/lsamp_top_asserts.sv
// Checker for the logic bus sampler control, status and result ports
`timescale 1ns/10ps
`include "lsamp_defs.vh"
module lsamp_chk (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Control strobes and values
   input wire thr_wr_in,
   input wire [7:0] thr_val_in,
   input wire tech_wr_in,
   input wire [2:0] tech_val_in,
   input wire couple_wr_in,
   input wire [1:0] grp_idx_in,
   input wire en_wr_in,
   input wire en_val_in,
   input wire cfg_wr_in,
   input wire [3:0] fmt_in,
   // Observed outputs
   input wire [3:0] grp_en_out,
   input wire conflict_out,
   input wire [2:0] tech_sel_out,
   input wire couple_out,
   input wire [7:0] act_thr_out,
   input wire [63:0] bus_state_out,
   input wire [3:0] res_valid_out,
   input wire [63:0] res_word_out,
   input wire [63:0] res_sext_out,
   input wire [127:0] res_time_out,
   input wire [3:0] res_signed_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   // Request sequences; a same-cycle preset write wins, so preset and coupling writes are excluded
   sequence s_en_req;
      en_wr_in && en_val_in;
   endsequence
   sequence s_dis_req;
      en_wr_in && !en_val_in;
   endsequence
   sequence s_thr_req;
      couple_out && thr_wr_in && !tech_wr_in && !couple_wr_in;
   endsequence
   a_enable_sets: assert property (s_en_req |=> grp_en_out[$past(grp_idx_in)])
      else $error("group enable not applied");
   a_disable_clears: assert property (s_dis_req |=> !grp_en_out[$past(grp_idx_in)])
      else $error("group disable not applied");
   a_conflict_cause: assert property (conflict_out |-> $past(en_wr_in && en_val_in))
      else $error("conflict flag without an enable");
   a_conflict_pulse: assert property (conflict_out |=> !conflict_out)
      else $error("conflict flag longer than one cycle");
   a_reset_coupled: assert property ($rose(rst_n_in) |-> couple_out && act_thr_out == `LSAMP_THR_RESET)
      else $error("coupling or threshold wrong after reset");
   a_thr_manual: assert property (s_thr_req |=> tech_sel_out == 3'h0 && act_thr_out == $past(thr_val_in))
      else $error("direct threshold write mishandled");
   a_tech_preset: assert property (tech_wr_in && tech_val_in == 3'h1 |=> act_thr_out == `LSAMP_THR_CMOS33)
      else $error("preset threshold not loaded");
   a_valid_spaced: assert property (|res_valid_out |=> (res_valid_out & $past(res_valid_out)) == 4'h0)
      else $error("result strobe on two cycles running");
   a_word_state: assert property (res_valid_out[3] |-> bus_state_out[63:48] == res_word_out[63:48])
      else $error("bus state differs from result word");
   a_sext_word: assert property (res_valid_out[3] |-> (res_sext_out[63:48] & res_word_out[63:48]) == res_word_out[63:48])
      else $error("extended word loses word bits");
   a_time_steps: assert property (res_valid_out[3] |-> res_time_out[127:96] != $past(res_time_out[127:96]))
      else $error("result timestamp not renewed");
   a_fmt_signed: assert property (cfg_wr_in |=> ##1 res_signed_out[$past(grp_idx_in, 2)] == ($past(fmt_in, 2) == 4'h5))
      else $error("signed flag does not follow format");
endmodule // lsamp_chk
bind lsamp_top lsamp_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .thr_wr_in(thr_wr_in),
   .thr_val_in(thr_val_in), .tech_wr_in(tech_wr_in), .tech_val_in(tech_val_in),
   .couple_wr_in(couple_wr_in), .grp_idx_in(grp_idx_in), .en_wr_in(en_wr_in),
   .en_val_in(en_val_in), .cfg_wr_in(cfg_wr_in), .fmt_in(fmt_in), .grp_en_out(grp_en_out),
   .conflict_out(conflict_out), .tech_sel_out(tech_sel_out), .couple_out(couple_out),
   .act_thr_out(act_thr_out), .bus_state_out(bus_state_out), .res_valid_out(res_valid_out),
   .res_word_out(res_word_out), .res_sext_out(res_sext_out), .res_time_out(res_time_out),
   .res_signed_out(res_signed_out));

// ### tb/lsamp_pod_model.sv
// Probe pod model: level codes of the sixteen probed lines
`timescale 1ns/10ps
module lsamp_pod_model (
   // Pattern for lines 1 to 14, raw level of line 0, burst request
   input wire [15:0] word_in,
   input wire [7:0] lvl0_in,
   input wire run_in,
   // Level codes, line n at [8n+7:8n]
   output reg [127:0] level_out
);
   reg link_clk;
   integer n;
   ////////////////////////////////////////////////////////////////////////////////
   // Line 15 toggles every 200 ns only during a burst and idles low; odd start offset
   // keeps its edges off the sample clock edges
   initial begin
      link_clk = 1'b0;
      #7;
      forever begin
         #200;
         link_clk = run_in ? ~link_clk : 1'b0;
      end
   end
   // Two pods of eight lines; codes sit well clear of any hysteresis band
   always @* begin
      level_out[7:0] = lvl0_in;
      for (n = 1; n < 15; n = n + 1) begin
         level_out[8*n +: 8] = word_in[n] ? 8'hc0 : 8'h20;
      end
      level_out[127:120] = link_clk ? 8'hc0 : 8'h20;
   end
endmodule // lsamp_pod_model

// ### tb/tb_logic_bus_sampler.sv
// Bench for the logic bus sampler: strobe tasks and port checks
`timescale 1ns/10ps
`include "lsamp_defs.vh"
module tb_logic_bus_sampler;
   reg mclk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [8:0] stb = 9'h000;
   reg [7:0] thr = 8'h80;
   reg [7:0] lvl0 = 8'h20;
   reg [7:0] hr, hf;
   reg [1:0] hys = 2'h0;
   reg [1:0] gi = 2'h0;
   reg [2:0] tech = 3'h0;
   reg [15:0] msk = 16'h0000;
   reg [15:0] word = 16'h0000;
   reg [3:0] fmt = 4'h0;
   reg [3:0] sl = 4'h0;
   reg [3:0] sk = 4'h0;
   reg [3:0] gsk = 4'h0;
   reg cpl = 1'b1;
   reg env = 1'b0;
   reg slope = 1'b0;
   reg run = 1'b0;
   reg pclk = 1'b0;
   wire [127:0] lev;
   wire [127:0] rtime;
   wire [63:0] bus, rword, rsext;
   wire [15:0] line;
   wire [7:0] athr;
   wire [3:0] gen, valid, sgn;
   wire [2:0] tsel;
   wire [1:0] ahys;
   wire conflict, cpl_o;
   integer num_errors = 0;
   integer compares = 0;
   integer cyc = 0;
   integer i, k, n_clk, n_res, n_bad;
   ////////////////////////////////////////////////////////////////////////////////
   // Pod select, pod set, clocked mode and clock source line are fixed for this bench
   lsamp_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .level_in(lev), .thr_wr_in(stb[0]),
      .thr_val_in(thr), .hys_val_in(hys), .tech_wr_in(stb[1]), .tech_val_in(tech),
      .couple_wr_in(stb[2]), .couple_val_in(cpl), .grp_idx_in(gi), .en_wr_in(stb[3]),
      .en_val_in(env), .mask_wr_in(stb[4]), .mask_val_in(msk), .pod_wr_in(stb[5]),
      .pod_sel_in(1'b0), .pod_val_in(1'b1), .cfg_wr_in(stb[6]), .clk_mode_in(1'b1),
      .clk_src_in(4'hf), .slope_in(slope), .fmt_in(fmt), .skew_wr_in(stb[7]),
      .skew_line_in(sl), .skew_val_in(sk), .gskew_wr_in(stb[8]), .gskew_val_in(gsk),
      .line_out(line), .grp_en_out(gen), .conflict_out(conflict), .tech_sel_out(tsel),
      .couple_out(cpl_o), .act_thr_out(athr), .act_hys_out(ahys), .bus_state_out(bus),
      .res_valid_out(valid), .res_word_out(rword), .res_sext_out(rsext),
      .res_time_out(rtime), .res_signed_out(sgn));
   lsamp_pod_model pod (.word_in(word), .lvl0_in(lvl0), .run_in(run), .level_out(lev));
   always #25 mclk_in = ~mclk_in;
   ////////////////////////////////////////////////////////////////////////////////
   // Tests take about 540 cycles; the ceiling leaves ample margin for a slow design
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors = num_errors + 1;
         print_verdict;
      end
   end
   task print_verdict;
      begin
         if (num_errors == 0 && compares > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [63:0] seen, input [63:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One-cycle strobe, then one cycle for the registered effect to land
   task go(input integer b);
      begin
         stb = 9'h001 << b;
         @(negedge mclk_in);
         stb = 9'h000;
         @(negedge mclk_in);
      end
   endtask
   task settle;
      repeat (12) @(negedge mclk_in);
   endtask
   // Toggle one line and count samples until the delayed copy follows
   task lat(input integer l, input integer e);
      integer n;
      begin
         n = 0;
         word[l] = ~word[l];
         while (line[l] !== word[l] && n < 40) begin
            @(negedge mclk_in);
            n = n + 1;
         end
         chk("latency", n, e);
      end
   endtask
   function [7:0] thr_of(input integer t);
      case (t)
         1: thr_of = `LSAMP_THR_CMOS33;
         2: thr_of = `LSAMP_THR_CMOS25;
         3: thr_of = `LSAMP_THR_CMOS18;
         4: thr_of = `LSAMP_THR_TTL;
         default: thr_of = `LSAMP_THR_ECL;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge mclk_in);
      rst_n_in = 1'b1;
      @(negedge mclk_in);
      chk("couple", cpl_o, 1);
      chk("thr", athr, `LSAMP_THR_RESET);
      for (i = 1; i < 6; i = i + 1) begin
         tech = i;
         go(1);
         chk("preset thr", athr, thr_of(i));
         chk("preset sel", tsel, i);
      end
      go(0);
      chk("manual sel", tsel, `LSAMP_TECH_MANUAL);
      // Step line 0 across each hysteresis band edge, one code either side
      for (k = 0; k < 3; k = k + 1) begin
         hys = k;
         go(0);
         hr = (k == 0) ? `LSAMP_HYS_AMT_NORMAL : (k == 1) ? `LSAMP_HYS_AMT_MAX : `LSAMP_HYS_AMT_RISE;
         hf = (k == 0) ? `LSAMP_HYS_AMT_NORMAL : (k == 1) ? `LSAMP_HYS_AMT_MAX : `LSAMP_HYS_AMT_FALL;
         lvl0 = 8'h80 + hr;
         settle;
         chk("rise edge", line[0], 0);
         lvl0 = 8'h81 + hr;
         settle;
         chk("rise over", line[0], 1);
         lvl0 = 8'h81 - hf;
         settle;
         chk("fall edge", line[0], 1);
         lvl0 = 8'h80 - hf;
         settle;
         chk("fall under", line[0], 0);
      end
      hys = 2'h0;
      go(0);
      // Skew: fixed path compensation, then per-line and global additions
      lat(2, 7);
      sl = 4'h1;
      sk = 4'h4;
      go(7);
      gsk = 4'h2;
      go(8);
      lat(1, 13);
      lat(2, 9);
      sk = 4'h0;
      go(7);
      gsk = 4'h0;
      go(8);
      // Decoupled threshold for group 1 becomes the active threshold once it is enabled
      gi = 2'h1;
      msk = 16'h0180;
      go(4);
      cpl = 1'b0;
      go(2);
      thr = 8'h60;
      go(0);
      env = 1'b1;
      go(3);
      chk("act thr", athr, 8'h60);
      chk("enables", gen, 4'h2);
      cpl = 1'b1;
      go(2);
      thr = 8'h80;
      go(0);
      // Pod set on group 0 overlaps line 7 of group 1
      gi = 2'h0;
      go(5);
      stb = 9'h008;
      @(negedge mclk_in);
      stb = 9'h000;
      chk("conflict", conflict, 1);
      chk("enables", gen, 4'h1);
      @(negedge mclk_in);
      chk("conflict end", conflict, 0);
      // Unclocked groups: pod 0 on group 0, sparse lines 9,11,13 on group 2
      gi = 2'h2;
      msk = 16'h2a00;
      go(4);
      go(3);
      word = 16'h2206;
      settle;
      chk("bus g0", bus[15:0], 16'h0006);
      chk("bus g2", bus[47:32], 16'h0005);
      gi = 2'h0;
      env = 1'b0;
      go(3);
      gi = 2'h3;
      env = 1'b1;
      msk = 16'h1006;
      go(4);
      go(3);
      word = 16'h3202;
      for (i = 0; i < 9; i = i + 1) begin
         fmt = i;
         go(6);
         chk("signed", sgn[3], i == 5);
      end
      // Clocked group 3 on line 15: one result per qualifying edge, none elsewhere
      for (k = 0; k < 2; k = k + 1) begin
         slope = k;
         fmt = `LSAMP_FMT_SIGNED;
         go(6);
         n_clk = 0;
         n_res = 0;
         n_bad = 0;
         run = 1'b1;
         for (i = 0; i < 130; i = i + 1) begin
            if (i == 100) run = 1'b0;
            @(negedge mclk_in);
            if (lev[127] !== pclk && lev[127] === ~slope) n_clk = n_clk + 1;
            pclk = lev[127];
            if (valid[3] === 1'b1) n_res = n_res + 1;
            if (valid[2:0] !== 3'h0) n_bad = n_bad + 1;
         end
         chk("results", n_res, n_clk);
         chk("unclocked res", n_bad, 0);
         chk("word", rword[63:48], 16'h0005);
         chk("sext", rsext[63:48], 16'hfffd);
      end
      print_verdict;
   end
endmodule // tb_logic_bus_sampler
